// [rtl/pmic_ctrl.sv]
// Power controller: serial target, registers, low-power sequencer and event line
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "pmic_cfg.svh"
module pmic_ctrl #(
  parameter int unsigned DEBOUNCE_CYC = `DEBOUNCE_CYC
) (
  // Clock, reset, enable
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       en_i,
  // Serial link
  pmic_if.dev             link,
  // Asynchronous supervisory inputs
  input  wire logic       low_power_request_pin_i,
  input  wire logic       warm_reset_input_i,
  input  wire logic       pushbutton_power_toggle_i,
  input  wire logic       under_voltage_i,
  input  wire logic       over_temperature_event_i,
  input  wire logic [3:0] regulator_low_i,
  input  wire logic       address_low_bit_strap_i,
  // Regulator controls
  output logic            main_converter_en_o,
  output logic            core_converter_en_o,
  output logic            core_sleep_level_o,
  output logic [1:0]      core_sleep_voltage_select_o,
  output logic [1:0]      linear_reg_en_o,
  output logic [1:0]      linear_reg_sleep_o,
  output logic            dsp_rail_en_o,
  // Status and reset
  output logic            low_power_o,
  output logic            processor_reset_pulse_b_o,
  output logic            power_event_line_o,
  output logic            power_event_line_oe_o
);
  // Two-stage synchroniser for every pin
  logic [11:0] s1_reg, s2_reg;
  wire  [11:0] async_w = {link.scl, link.sda, low_power_request_pin_i, warm_reset_input_i,
                          pushbutton_power_toggle_i, under_voltage_i, over_temperature_event_i,
                          address_low_bit_strap_i, regulator_low_i};
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_reg <= 12'hC00;
      s2_reg <= 12'hC00;
    end else if (en_i) begin
      s1_reg <= async_w;
      s2_reg <= s1_reg;
    end
  end
  wire       scl_w    = s2_reg[11];
  wire       sda_w    = s2_reg[10];
  wire       req_w    = s2_reg[9];
  wire       warm_w   = s2_reg[8];
  wire       pb_w     = s2_reg[7];
  wire       uv_w     = s2_reg[6];
  wire       ot_w     = s2_reg[5];
  wire       strap_w  = s2_reg[4];
  wire       reglow_w = |s2_reg[3:0];

  // Edge history
  logic scl_d_reg, sda_d_reg, pb_d_reg, warm_db_d_reg, trig_d_reg;
  logic warm_db_reg;
  logic [7:0] flags_reg, mask_reg, core_reg, linreg_reg, ctrl_reg;
  wire  trig_w     = ctrl_reg[`CTRL_ARM_BIT] && req_w;
  wire  trig_rise  = trig_w && !trig_d_reg;
  wire  scl_rise   = scl_w && !scl_d_reg;
  wire  scl_fall   = !scl_w && scl_d_reg;
  wire  start_w    = scl_w && scl_d_reg && !sda_w && sda_d_reg;
  wire  stop_w     = scl_w && scl_d_reg && sda_w && !sda_d_reg;
  wire  pb_rise    = pb_w && !pb_d_reg;
  wire  warm_rise  = warm_db_reg && !warm_db_d_reg;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_d_reg     <= 1'b1;
      sda_d_reg     <= 1'b1;
      pb_d_reg      <= 1'b0;
      warm_db_d_reg <= 1'b0;
      trig_d_reg    <= 1'b0;
    end else if (en_i) begin
      scl_d_reg     <= scl_w;
      sda_d_reg     <= sda_w;
      pb_d_reg      <= pb_w;
      warm_db_d_reg <= warm_db_reg;
      trig_d_reg    <= trig_w;
    end
  end

  // Warm reset debounce: level must hold for the whole window
  logic [21:0] db_cnt_reg;
  wire         db_diff = warm_w != warm_db_reg;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      db_cnt_reg  <= 22'h0;
      warm_db_reg <= 1'b0;
    end else if (en_i) begin
      if (!db_diff) begin
        db_cnt_reg <= 22'h0;
      end else if (db_cnt_reg == 22'(DEBOUNCE_CYC - 1)) begin
        db_cnt_reg  <= 22'h0;
        warm_db_reg <= warm_w;
      end else begin
        db_cnt_reg <= db_cnt_reg + 22'h1;
      end
    end
  end

  // Low-power sequencer
  pmic_pkg::lp_state_e lp_reg, lp_next;
  logic [12:0] tmr_reg;
  wire  lp_exit_w = uv_w || ot_w || !req_w || pb_rise;
  wire  stab_done = tmr_reg == 13'(`STAB_CYC - 1);
  wire  rst_done  = tmr_reg == 13'(`RST_PULSE_CYC - 1);
  always_comb begin
    lp_next = lp_reg;
    case (lp_reg)
      pmic_pkg::LP_RUN: begin
        if (warm_rise) lp_next = pmic_pkg::LP_RST;
        else if (trig_rise) lp_next = pmic_pkg::LP_SLEEP;
      end
      pmic_pkg::LP_SLEEP: begin
        if (warm_rise) lp_next = pmic_pkg::LP_STAB;
        else if (lp_exit_w) lp_next = pmic_pkg::LP_RUN;
      end
      pmic_pkg::LP_STAB: if (stab_done) lp_next = pmic_pkg::LP_RST;
      pmic_pkg::LP_RST:  if (rst_done) lp_next = pmic_pkg::LP_RUN;
      default: lp_next = pmic_pkg::LP_RUN;
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lp_reg  <= pmic_pkg::LP_RUN;
      tmr_reg <= 13'h0;
    end else if (en_i) begin
      lp_reg  <= lp_next;
      tmr_reg <= (lp_next != lp_reg) ? 13'h0 : tmr_reg + 13'h1;
    end
  end
  wire sleep_w = lp_reg == pmic_pkg::LP_SLEEP;

  // Serial target
  pmic_pkg::i2c_state_e st_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] sh_reg, ptr_reg;
  logic [1:0] byte_cnt_reg;
  logic       rw_reg, nack_reg, sda_drv_reg;
  logic       wr_reg;
  logic [7:0] wr_data_reg;
  wire        addr_hit = sh_reg[7:1] == {`ADDR_HIGH_BITS, strap_w};
  wire [7:0]  status_w = {3'h0, reglow_w, ot_w, uv_w, req_w, sleep_w};
  // Register map readback, no gating by power state
  wire [7:0]  rd_w = (ptr_reg == `REG_STATUS) ? status_w :
                     (ptr_reg == `REG_FLAGS)  ? flags_reg :
                     (ptr_reg == `REG_MASK)   ? mask_reg :
                     (ptr_reg == `REG_CORE)   ? core_reg :
                     (ptr_reg == `REG_LINREG) ? linreg_reg :
                     (ptr_reg == `REG_CTRL)   ? ctrl_reg : `UNMAPPED_READ;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg       <= pmic_pkg::I2C_IDLE;
      bit_cnt_reg  <= 4'h0;
      sh_reg       <= 8'h00;
      ptr_reg      <= 8'h00;
      byte_cnt_reg <= 2'h0;
      rw_reg       <= 1'b0;
      nack_reg     <= 1'b0;
      sda_drv_reg  <= 1'b0;
      wr_reg       <= 1'b0;
      wr_data_reg  <= 8'h00;
    end else if (en_i) begin
      wr_reg <= 1'b0;
      if (start_w) begin
        st_reg       <= pmic_pkg::I2C_RX;
        bit_cnt_reg  <= 4'h0;
        byte_cnt_reg <= 2'h0;
        sda_drv_reg  <= 1'b0;
      end else if (stop_w) begin
        st_reg      <= pmic_pkg::I2C_IDLE;
        sda_drv_reg <= 1'b0;
      end else begin
        case (st_reg)
          pmic_pkg::I2C_RX: begin
            if (scl_rise) begin
              sh_reg      <= {sh_reg[6:0], sda_w};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              if (byte_cnt_reg == 2'h0 && !addr_hit) begin
                st_reg <= pmic_pkg::I2C_IDLE;
              end else begin
                st_reg      <= pmic_pkg::I2C_ACK;
                sda_drv_reg <= 1'b1;
                if (byte_cnt_reg == 2'h0) rw_reg <= sh_reg[0];
                else if (byte_cnt_reg == 2'h1) ptr_reg <= sh_reg;
                else begin
                  wr_reg      <= 1'b1;
                  wr_data_reg <= sh_reg;
                end
                if (byte_cnt_reg != 2'h2) byte_cnt_reg <= byte_cnt_reg + 2'h1;
              end
            end
          end
          pmic_pkg::I2C_ACK: begin
            if (scl_fall) begin
              if (rw_reg) begin
                st_reg      <= pmic_pkg::I2C_TX;
                sh_reg      <= rd_w;
                sda_drv_reg <= !rd_w[7];
                bit_cnt_reg <= 4'h1;
              end else begin
                st_reg      <= pmic_pkg::I2C_RX;
                sda_drv_reg <= 1'b0;
                bit_cnt_reg <= 4'h0;
              end
            end
          end
          pmic_pkg::I2C_TX: begin
            if (scl_fall) begin
              if (bit_cnt_reg == 4'h8) begin
                st_reg      <= pmic_pkg::I2C_RACK;
                sda_drv_reg <= 1'b0;
              end else begin
                sda_drv_reg <= !sh_reg[6];
                sh_reg      <= {sh_reg[6:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
          pmic_pkg::I2C_RACK: begin
            if (scl_rise) nack_reg <= sda_w;
            else if (scl_fall) begin
              if (nack_reg) st_reg <= pmic_pkg::I2C_IDLE;
              else begin
                st_reg      <= pmic_pkg::I2C_TX;
                sh_reg      <= rd_w;
                sda_drv_reg <= !rd_w[7];
                bit_cnt_reg <= 4'h1;
              end
            end
          end
          default: sda_drv_reg <= 1'b0;
        endcase
      end
    end
  end
  // Oversampled edges make the target rate-agnostic up to fast mode
  assign link.dev_sda_o  = 1'b0;
  assign link.dev_sda_oe = sda_drv_reg;

  // Registers and events
  wire [7:0] set_w   = {1'b0, pb_rise, warm_rise, sleep_w && lp_next != pmic_pkg::LP_SLEEP,
                        trig_rise && lp_reg == pmic_pkg::LP_RUN, reglow_w, ot_w, uv_w};
  wire [7:0] clr_w   = (wr_reg && ptr_reg == `REG_FLAGS) ? wr_data_reg : 8'h00;
  wire [7:0] flags_next = (flags_reg & ~clr_w) | set_w;
  wire       wr_mask = wr_reg && ptr_reg == `REG_MASK;
  wire       wr_core = wr_reg && ptr_reg == `REG_CORE;
  wire       wr_lin  = wr_reg && ptr_reg == `REG_LINREG;
  wire       wr_ctrl = wr_reg && ptr_reg == `REG_CTRL;
  wire       core_off_w = sleep_w && core_reg[`CORE_OFF_BIT];
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flags_reg  <= 8'h00;
      mask_reg   <= `MASK_RST;
      core_reg   <= `CORE_RST;
      linreg_reg <= `LINREG_RST;
      ctrl_reg   <= `CTRL_RST;
    end else if (en_i) begin
      flags_reg <= flags_next;
      if (wr_mask) mask_reg <= wr_data_reg;
      if (wr_core) core_reg <= wr_data_reg;
      if (wr_lin)  linreg_reg <= wr_data_reg;
      if (wr_ctrl) ctrl_reg <= wr_data_reg;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      main_converter_en_o         <= 1'b1;
      core_converter_en_o         <= 1'b1;
      core_sleep_level_o          <= 1'b0;
      core_sleep_voltage_select_o <= 2'h0;
      linear_reg_en_o             <= 2'h3;
      linear_reg_sleep_o          <= 2'h0;
      dsp_rail_en_o               <= 1'b1;
      low_power_o                 <= 1'b0;
      processor_reset_pulse_b_o   <= 1'b1;
      power_event_line_oe_o       <= 1'b0;
    end else if (en_i) begin
      main_converter_en_o         <= 1'b1;
      core_converter_en_o         <= !core_off_w;
      core_sleep_level_o          <= sleep_w && !core_off_w;
      core_sleep_voltage_select_o <= core_reg[`CORE_VSEL_LSB +: 2];
      linear_reg_en_o             <= sleep_w ? ~linreg_reg[1:0] : 2'h3;
      linear_reg_sleep_o          <= sleep_w ? ~linreg_reg[1:0] : 2'h0;
      dsp_rail_en_o               <= ctrl_reg[`CTRL_DSP_BIT];
      low_power_o                 <= sleep_w;
      processor_reset_pulse_b_o   <= lp_reg != pmic_pkg::LP_RST;
      power_event_line_oe_o       <= (|(flags_reg & mask_reg)) || reglow_w;
    end
  end
  assign power_event_line_o = 1'b0;
endmodule

// [inc/pmic_cfg.svh]
// Offsets, field positions, reset values and timing counts of the power controller link
`ifndef PMIC_CFG_SVH
`define PMIC_CFG_SVH
`define ADDR_HIGH_BITS   6'h24
`define REG_STATUS       8'h00
`define REG_FLAGS        8'h01
`define REG_MASK         8'h02
`define REG_CORE         8'h03
`define REG_LINREG       8'h04
`define REG_CTRL         8'h05
`define UNMAPPED_READ    8'hFF
`define CORE_OFF_BIT     0
`define CORE_VSEL_LSB    1
`define CTRL_ARM_BIT     0
`define CTRL_DSP_BIT     1
`define CORE_RST         8'h00
`define LINREG_RST       8'h00
`define CTRL_RST         8'h02
`define MASK_RST         8'h7F
`define CLK_KHZ          40000
`define DEBOUNCE_MS      56
`define DEBOUNCE_CYC     (`DEBOUNCE_MS * `CLK_KHZ)
`define RST_PULSE_US     100
`define RST_PULSE_CYC    (`RST_PULSE_US * `CLK_KHZ / 1000)
`define STAB_US          50
`define STAB_CYC         (`STAB_US * `CLK_KHZ / 1000)
`define SCL_MAX_KHZ      400
`define SCL_QUARTER_CYC  (`CLK_KHZ / (`SCL_MAX_KHZ * 4))
`define HREG_TADDR       3'h0
`define HREG_PTR         3'h1
`define HREG_WDATA       3'h2
`define HREG_CMD         3'h3
`define HREG_STATUS      3'h4
`define HREG_RDATA       3'h5
`define CMD_WRITE_BIT    0
`define CMD_READ_BIT     1
`define CMD_PTR_ONLY_BIT 2
`endif

// [inc/pmic_pkg.sv]
// Types shared by both ends of the power controller link
package pmic_pkg;
  typedef enum logic [2:0] {
    I2C_IDLE = 3'h0,
    I2C_RX   = 3'h1,
    I2C_ACK  = 3'h2,
    I2C_TX   = 3'h3,
    I2C_RACK = 3'h4
  } i2c_state_e;
  typedef enum logic [1:0] {
    LP_RUN   = 2'h0,
    LP_SLEEP = 2'h1,
    LP_STAB  = 2'h2,
    LP_RST   = 2'h3
  } lp_state_e;
  typedef enum logic [1:0] {
    H_IDLE  = 2'h0,
    H_START = 2'h1,
    H_BIT   = 2'h2,
    H_STOP  = 2'h3
  } host_state_e;
endpackage

// [inc/pmic_if.sv]
// Open-drain serial link between the host controller and the power controller
`timescale 1ns/1ps
interface pmic_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // Wired-AND with pull-ups
  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface

// [rtl/pmic_host.sv]
// Host-side serial master driven from a simple register port
`timescale 1ns/1ps
`include "pmic_cfg.svh"
module pmic_host #(
  parameter int unsigned QUARTER_CYC = `SCL_QUARTER_CYC
) (
  // Clock, reset, enable
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       en_i,
  // Register port
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic [7:0]      rdata_o,
  // Serial link
  pmic_if.host            link
);
  logic [6:0] taddr_reg;
  logic [7:0] ptr_reg, wdata_reg, rx_reg, sh_reg;
  logic       busy_reg, nack_reg, rd_op_reg, ptr_only_reg;
  logic       scl_oe_reg, sda_oe_reg;
  logic       s1_reg, s2_reg;
  logic [7:0] qcnt_reg;
  logic [1:0] q_reg, byte_reg;
  logic [3:0] bit_reg;
  pmic_pkg::host_state_e st_reg;

  wire       tick     = qcnt_reg == 8'(QUARTER_CYC - 1);
  wire       go_w     = wr_i && addr_i == `HREG_CMD && !busy_reg;
  wire       go_wr    = go_w && wdata_i[`CMD_WRITE_BIT];
  wire       go_rd    = go_w && wdata_i[`CMD_READ_BIT] && !wdata_i[`CMD_WRITE_BIT];
  wire       rx_byte  = rd_op_reg && byte_reg == 2'h1;
  wire [1:0] last_w   = rd_op_reg ? 2'h1 : (ptr_only_reg ? 2'h1 : 2'h2);
  wire [7:0] next_byte = (byte_reg == 2'h0) ? ptr_reg : wdata_reg;
  wire [7:0] rd_mux   = (addr_i == `HREG_TADDR)  ? {1'b0, taddr_reg} :
                        (addr_i == `HREG_PTR)    ? ptr_reg :
                        (addr_i == `HREG_WDATA)  ? wdata_reg :
                        (addr_i == `HREG_STATUS) ? {6'h00, nack_reg, busy_reg} :
                        (addr_i == `HREG_RDATA)  ? rx_reg : 8'h00;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_reg  <= 1'b1;
      s2_reg  <= 1'b1;
      rdata_o <= 8'h00;
    end else if (en_i) begin
      s1_reg  <= link.sda;
      s2_reg  <= s1_reg;
      rdata_o <= rd_i ? rd_mux : 8'h00;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      taddr_reg <= {`ADDR_HIGH_BITS, 1'b0};
      ptr_reg   <= 8'h00;
      wdata_reg <= 8'h00;
    end else if (en_i && wr_i) begin
      if (addr_i == `HREG_TADDR) taddr_reg <= wdata_i[6:0];
      if (addr_i == `HREG_PTR && !busy_reg) ptr_reg <= wdata_i;
      if (addr_i == `HREG_WDATA && !busy_reg) wdata_reg <= wdata_i;
    end
  end

  // Bit engine: quarter 0 clock low, 1 data change, 2 clock release, 3 sample
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg       <= pmic_pkg::H_IDLE;
      busy_reg     <= 1'b0;
      nack_reg     <= 1'b0;
      rd_op_reg    <= 1'b0;
      ptr_only_reg <= 1'b0;
      scl_oe_reg   <= 1'b0;
      sda_oe_reg   <= 1'b0;
      qcnt_reg     <= 8'h00;
      q_reg        <= 2'h0;
      byte_reg     <= 2'h0;
      bit_reg      <= 4'h0;
      sh_reg       <= 8'h00;
      rx_reg       <= 8'h00;
    end else if (en_i) begin
      qcnt_reg <= (tick || st_reg == pmic_pkg::H_IDLE) ? 8'h00 : qcnt_reg + 8'h01;
      if (tick && st_reg != pmic_pkg::H_IDLE) q_reg <= q_reg + 2'h1;
      case (st_reg)
        pmic_pkg::H_IDLE: begin
          q_reg <= 2'h0;
          if (go_wr || go_rd) begin
            st_reg       <= pmic_pkg::H_START;
            busy_reg     <= 1'b1;
            nack_reg     <= 1'b0;
            rd_op_reg    <= go_rd;
            ptr_only_reg <= wdata_i[`CMD_PTR_ONLY_BIT];
            sh_reg       <= {taddr_reg, go_rd};
            byte_reg     <= 2'h0;
            bit_reg      <= 4'h0;
          end
        end
        pmic_pkg::H_START: begin
          if (tick && q_reg == 2'h1) sda_oe_reg <= 1'b1;
          if (tick && q_reg == 2'h3) st_reg <= pmic_pkg::H_BIT;
        end
        pmic_pkg::H_BIT: begin
          if (tick) begin
            case (q_reg)
              2'h0: scl_oe_reg <= 1'b1;
              2'h1: sda_oe_reg <= bit_reg[3] ? 1'b0 : (!rx_byte && !sh_reg[7]);
              2'h2: scl_oe_reg <= 1'b0;
              default: begin
                if (bit_reg == 4'h8) begin
                  if (!rx_byte && s2_reg) nack_reg <= 1'b1;
                  bit_reg <= 4'h0;
                  if ((!rx_byte && s2_reg) || byte_reg == last_w) st_reg <= pmic_pkg::H_STOP;
                  else begin
                    byte_reg <= byte_reg + 2'h1;
                    sh_reg   <= next_byte;
                  end
                end else begin
                  if (rx_byte) rx_reg <= {rx_reg[6:0], s2_reg};
                  sh_reg  <= {sh_reg[6:0], 1'b0};
                  bit_reg <= bit_reg + 4'h1;
                end
              end
            endcase
          end
        end
        pmic_pkg::H_STOP: begin
          if (tick) begin
            case (q_reg)
              2'h0: scl_oe_reg <= 1'b1;
              2'h1: sda_oe_reg <= 1'b1;
              2'h2: scl_oe_reg <= 1'b0;
              default: begin
                sda_oe_reg <= 1'b0;
                busy_reg   <= 1'b0;
                st_reg     <= pmic_pkg::H_IDLE;
              end
            endcase
          end
        end
        default: st_reg <= pmic_pkg::H_IDLE;
      endcase
    end
  end
  assign link.host_scl_o  = 1'b0;
  assign link.host_scl_oe = scl_oe_reg;
  assign link.host_sda_o  = 1'b0;
  assign link.host_sda_oe = sda_oe_reg;
endmodule

// [testbench/pmic_assertions.sv]
// Link checker for the power controller serial bus
`timescale 1ns/1ps
module pmic_assertions (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Link signals
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic [3:0] bits_reg;
  logic [1:0] byte_reg;
  logic       rw_reg;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Bit and byte position within a frame
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {bits_reg, byte_reg, rw_reg} <= 7'h00;
    end else if ($fell(sda) && scl) begin
      {bits_reg, byte_reg, rw_reg} <= 7'h00;
    end else if ($rose(scl)) begin
      bits_reg <= (bits_reg == 4'h9) ? 4'h1 : bits_reg + 4'h1;
      byte_reg <= byte_reg + {1'b0, bits_reg == 4'h9};
      rw_reg   <= (bits_reg == 4'h7 && byte_reg == 2'h0) ? sda : rw_reg;
    end
  end
  AST_DEV_CHANGE_LOW: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device data changed while clock high");
  AST_WIRE_STABLE: assert property ($changed(sda) && scl && $past(scl) |-> $changed(host_sda_oe))
    else $error("data moved during clock high without start or stop");
  AST_HIGH_MIN: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  AST_LOW_MIN: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
  AST_START_HOLD: assert property ($fell(sda) && scl |-> scl [*8])
    else $error("clock fell right after start");
  AST_ACK_HELD: assert property (dev_sda_oe && $rose(scl) |-> (dev_sda_oe && !sda) [*8])
    else $error("device low level not held through clock high");
  AST_ACK_EACH: assert property ($rose(scl) && bits_reg == 4'h8 && !(rw_reg && byte_reg != 2'h0)
    |-> dev_sda_oe && !sda)
    else $error("received byte not acknowledged");
  AST_NACK_RELEASE: assert property ($rose(scl) && bits_reg == 4'h8 && rw_reg && byte_reg != 2'h0
    |-> !dev_sda_oe && sda)
    else $error("device holds data at final read acknowledge");
endmodule

// [testbench/test_pmic_i2c_low_power_control.sv]
// Testbench joining the serial host and the power controller
`timescale 1ns/1ps
`include "pmic_cfg.svh"
module test_pmic_i2c_low_power_control;
  logic        clk_i;
  logic        rst_b_i;
  logic [2:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        req;
  logic        warm;
  logic        pb;
  logic        uv;
  logic        ot;
  logic [3:0]  reg_low;
  logic        strap;
  logic [11:0] st;
  logic        ev_o;
  logic        ev_oe;
  int          fails = 0;
  int          compares = 0;
  pmic_if pmic_if_i ();
  pmic_host pmic_host_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .en_i(1'b1), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .link(pmic_if_i));
  pmic_ctrl #(.DEBOUNCE_CYC(20)) pmic_ctrl_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .en_i(1'b1),
    .link(pmic_if_i), .low_power_request_pin_i(req), .warm_reset_input_i(warm),
    .pushbutton_power_toggle_i(pb), .under_voltage_i(uv), .over_temperature_event_i(ot),
    .regulator_low_i(reg_low), .address_low_bit_strap_i(strap), .main_converter_en_o(st[0]),
    .core_converter_en_o(st[1]), .core_sleep_level_o(st[2]), .core_sleep_voltage_select_o(st[4:3]),
    .linear_reg_en_o(st[6:5]), .linear_reg_sleep_o(st[8:7]), .dsp_rail_en_o(st[9]), .low_power_o(st[10]),
    .processor_reset_pulse_b_o(st[11]), .power_event_line_o(ev_o), .power_event_line_oe_o(ev_oe));
  pmic_assertions pmic_assertions_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .host_sda_oe(pmic_if_i.host_sda_oe),
    .dev_sda_oe(pmic_if_i.dev_sda_oe), .scl(pmic_if_i.scl), .sda(pmic_if_i.sda));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic hw(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic hr(input logic [2:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk_i);
  endtask
  task automatic idle;
    logic [7:0] s;
    s = 8'h01;
    for (int i = 0; i < 4000 && s[0] !== 1'b0; i++) hr(3'h4, s);
    chk({4'h0, s}, 12'h000);
  endtask
  task automatic dw(input logic [7:0] p, input logic [7:0] v);
    hw(3'h1, p);
    hw(3'h2, v);
    hw(3'h3, 8'h01);
    idle;
  endtask
  task automatic dr(input logic [7:0] p, output logic [7:0] v);
    hw(3'h1, p);
    hw(3'h3, 8'h05);
    idle;
    hw(3'h3, 8'h02);
    idle;
    hr(3'h5, v);
  endtask
  task automatic t_regs;
    logic [7:0] d;
    hw(3'h0, {1'b0, `ADDR_HIGH_BITS, 1'b0});
    dw(`REG_CORE, 8'h07);
    dr(`REG_CORE, d);
    chk({4'h0, d}, 12'h007);
    dr(8'h06, d);
    chk({4'h0, d}, 12'h0FF);
    dw(`REG_CTRL, 8'h00);
    chk({11'h000, st[9]}, 12'h000);
    dw(`REG_CTRL, 8'h02);
    chk({11'h000, st[9]}, 12'h001);
    strap <= 1'b1;
    hw(3'h0, {1'b0, `ADDR_HIGH_BITS, 1'b1});
    dw(`REG_MASK, 8'h3C);
    dr(`REG_MASK, d);
    chk({4'h0, d}, 12'h03C);
    $display("test regs done");
  endtask
  task automatic t_sleep;
    logic [7:0] d;
    dw(`REG_CORE, 8'h05);
    dw(`REG_LINREG, 8'h01);
    req <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(st, 12'hA73);
    dw(`REG_CTRL, 8'h03);
    chk(st, 12'hF51);
    dr(`REG_STATUS, d);
    chk({4'h0, d}, 12'h003);
    req <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(st, 12'hA73);
    dw(`REG_CORE, 8'h04);
    req <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(st, 12'hF57);
    $display("test sleep done");
  endtask
  task automatic t_exit;
    int n;
    warm <= 1'b1;
    repeat (10) @(posedge clk_i);
    warm <= 1'b0;
    repeat (30) @(posedge clk_i);
    chk({11'h000, st[10]}, 12'h001);
    for (int i = 0; i < 4; i++) begin
      req <= 1'b0;
      repeat (8) @(posedge clk_i);
      req <= 1'b1;
      repeat (8) @(posedge clk_i);
      chk({11'h000, st[10]}, 12'h001);
      {warm, pb, uv, ot} <= 4'h1 << i;
      repeat (40) @(posedge clk_i);
      chk({11'h000, st[10]}, 12'h000);
      {warm, pb, uv, ot} <= 4'h0;
    end
    n = 0;
    for (int i = 0; i < 8000; i++) begin
      @(posedge clk_i);
      n += (st[11] === 1'b0);
    end
    chk(n[11:0], 12'(`RST_PULSE_CYC));
    dw(`REG_MASK, 8'h00);
    chk({10'h000, ev_o, ev_oe}, 12'h000);
    reg_low <= 4'h4;
    repeat (8) @(posedge clk_i);
    chk({10'h000, ev_o, ev_oe}, 12'h001);
    reg_low <= 4'h0;
    dw(`REG_MASK, 8'h7F);
    chk({10'h000, ev_o, ev_oe}, 12'h001);
    $display("test exit done");
  endtask
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    fails++;
    test_done;
  end
  initial begin
    {rst_b_i, wr, rd, req, warm, pb, uv, ot, reg_low, strap, addr, wdata} = 24'h000000;
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_regs;
    t_sleep;
    t_exit;
    test_done;
  end
endmodule
